/* hw/gcsb_bank.sv */
// gcsb_bank: global configuration, sticky status, uart write
// counter, uart node config and input readout registers.
// assumes register port and driver events on sys_clk_i; pins async.
`timescale 1ns/1ps
`default_nettype none
module gcsb_bank
  import gcsb_pkg::*;
(
  // clock and reset
  input  wire logic                      sys_clk_i,
  input  wire logic                      srst_i,
  // register port
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  input  wire logic [gcsb_pkg::AW-1:0]   reg_addr_i,
  input  wire logic [gcsb_pkg::DW-1:0]   reg_wdata_i,
  input  wire logic                      uart_mode_i,
  output logic      [gcsb_pkg::DW-1:0]   reg_rdata_o,
  // driver events
  input  wire logic                      drv_shutdown_i,
  input  wire logic                      temp_ok_i,
  input  wire logic                      pump_uv_i,
  input  wire logic                      fault_req_i,
  input  wire logic                      compare_req_i,
  input  wire logic [gcsb_pkg::DW-1:0]   motion_target_reg_i,
  input  wire logic [1:0]                hold_current_setting_i,
  // pins
  input  wire logic                      left_ref_pin_i,
  input  wire logic                      right_ref_pin_i,
  input  wire logic                      ext_step_source_sel_i,
  input  wire logic                      enc_a_halt_pin_i,
  input  wire logic                      address_increment_pin_i,
  output logic                           fault_out_pin_o,
  output logic                           fault_out_pin_oe_o,
  output logic                           compare_out_pin_o,
  output logic                           compare_out_pin_oe_o,
  // to motor logic
  output logic [gcsb_pkg::GLOBAL_CONFIGURATION_W-1:0]   global_configuration_o,
  output logic                           seq_halt_o,
  output logic                           small_hyst_o,
  output logic                           direct_mode_o,
  output logic [gcsb_pkg::COIL_W-1:0]    coil_a_o,
  output logic [gcsb_pkg::COIL_W-1:0]    coil_b_o,
  output logic                           probe_en_o,
  output logic [1:0]                     probe_sel_o,
  output logic                           drv_hold_off_o,
  output logic [7:0]                     uart_node_address_o,
  output logic [7:0]                     reply_delay_bits_o
);
  import gcsb_pkg::*;

  ////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [GLOBAL_CONFIGURATION_W-1:0] global_configuration;
    logic [GLOBAL_STATUS_FLAGS_W-1:0] global_status_flags;
    logic [CNT_W-1:0]   uart_write_counter;
    logic [NCFG_W-1:0]  ncfg;
    logic [NPIN-1:0]    s1;
    logic [NPIN-1:0]    s2;
    logic [DW-1:0]      rdata;
    logic               f_o;
    logic               f_oe;
    logic               c_o;
    logic               c_oe;
    logic               halt;
    logic               hold_off;
    logic [COIL_W-1:0]  coil_a;
    logic [COIL_W-1:0]  coil_b;
    logic [7:0]         naddr;
    logic [7:0]         dly;
  } gcsb_state_t;

  gcsb_state_t st;
  gcsb_state_t next_st;

  // drive style: returns {level, enable}
  function automatic logic [1:0] pin_drive(input logic pp, input logic act);
    pin_drive = pp ? {act, 1'b1} : {1'b0, act};
  endfunction

  ////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic wr;
    logic [GLOBAL_STATUS_FLAGS_W-1:0] clr;
    logic [GLOBAL_STATUS_FLAGS_W-1:0] set;
    logic [DW-1:0] inrd;
    wr = 1'b0;
    clr = '0;
    set = '0;
    inrd = '0;
    next_st = st;
    // pin synchronisers
    next_st.s1 = {address_increment_pin_i, enc_a_halt_pin_i,
                  ext_step_source_sel_i, right_ref_pin_i, left_ref_pin_i};
    next_st.s2 = st.s1;
    // register writes
    wr = reg_wr_i;
    if (wr && reg_addr_i == ADDR_GLOBAL_CONFIGURATION)
      next_st.global_configuration = reg_wdata_i[GLOBAL_CONFIGURATION_W-1:0];
    if (wr && reg_addr_i == ADDR_NODECFG)
      next_st.ncfg = reg_wdata_i[NCFG_W-1:0];
    if (wr && reg_addr_i == ADDR_GLOBAL_STATUS_FLAGS)
      clr = reg_wdata_i[GLOBAL_STATUS_FLAGS_W-1:0];
    if (!temp_ok_i)
      clr[ST_DRV] = 1'b0;
    set[ST_DRV]  = drv_shutdown_i;
    set[ST_UVCP] = pump_uv_i;
    next_st.global_status_flags = (st.global_status_flags & ~clr) | set;
    if (wr && uart_mode_i)
      next_st.uart_write_counter = st.uart_write_counter + 8'h01;
    // input readout
    inrd[IN_LEFT]   = st.s2[P_LEFT];
    inrd[IN_RIGHT]  = st.s2[P_RIGHT];
    inrd[IN_SDMODE] = st.s2[P_SD];
    // read data, unmapped and write-only read zero
    next_st.rdata = st.rdata;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        ADDR_GLOBAL_CONFIGURATION: next_st.rdata = {{(DW-GLOBAL_CONFIGURATION_W){1'b0}}, st.global_configuration};
        ADDR_GLOBAL_STATUS_FLAGS: next_st.rdata = {{(DW-GLOBAL_STATUS_FLAGS_W){1'b0}}, st.global_status_flags};
        ADDR_UART_WRITE_COUNTER: next_st.rdata = {{(DW-CNT_W){1'b0}}, st.uart_write_counter};
        ADDR_INPUT: next_st.rdata = inrd;
        default:    next_st.rdata = '0;
      endcase
    end
    // output pins
    {next_st.f_o, next_st.f_oe} = pin_drive(st.global_configuration[GC_FAULT_PP], fault_req_i);
    {next_st.c_o, next_st.c_oe} = pin_drive(st.global_configuration[GC_CMP_PP], compare_req_i);
    next_st.halt = st.global_configuration[GC_STOP_EN] & st.s2[P_ENCA];
    next_st.hold_off = pump_uv_i;
    // direct coil currents
    next_st.coil_a = '0;
    next_st.coil_b = '0;
    if (st.global_configuration[GC_DIRECT])
    begin
      next_st.coil_a = motion_target_reg_i[COIL_A_LSB +: COIL_W];
      next_st.coil_b = motion_target_reg_i[COIL_B_LSB +: COIL_W];
    end
    // node address and reply delay
    next_st.naddr = st.ncfg[NC_ADDR_LSB +: 8] + {7'h00, st.s2[P_NEXT]};
    next_st.dly = 8'({st.ncfg[NC_DLY_LSB + 1 +: NC_DLY_W - 1], 1'b1}) * DLY_UNIT;
    // synchronous reset
    if (srst_i)
    begin
      next_st = '0;
      next_st.global_configuration = GLOBAL_CONFIGURATION_RST;
      next_st.global_status_flags = GLOBAL_STATUS_FLAGS_RST;
      next_st.uart_write_counter = CNT_RST;
      next_st.ncfg  = NCFG_RST;
      next_st.dly   = DLY_UNIT;
    end
  end

  ////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk_i)
  begin
    st <= next_st;
  end

  ////////////////////////////////////////////////////////////////
  // outputs
  assign reg_rdata_o          = st.rdata;
  assign fault_out_pin_o      = st.f_o;
  assign fault_out_pin_oe_o   = st.f_oe;
  assign compare_out_pin_o    = st.c_o;
  assign compare_out_pin_oe_o = st.c_oe;
  assign global_configuration_o              = st.global_configuration;
  assign seq_halt_o           = st.halt;
  assign small_hyst_o         = st.global_configuration[GC_SMALL_HY];
  assign direct_mode_o        = st.global_configuration[GC_DIRECT];
  assign coil_a_o             = st.coil_a;
  assign coil_b_o             = st.coil_b;
  assign probe_en_o           = st.global_configuration[GC_TEST];
  assign probe_sel_o          = hold_current_setting_i;
  assign drv_hold_off_o       = st.hold_off;
  assign uart_node_address_o  = st.naddr;
  assign reply_delay_bits_o   = st.dly;

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  property p_reset_flag;
    $past(srst_i) |-> st.global_status_flags[ST_RESET] && st.global_configuration == GLOBAL_CONFIGURATION_RST;
  endproperty
  a_reset_flag: assert property (p_reset_flag) else $error("reset flag missing");

  property p_w1c;
    reg_wr_i && reg_addr_i == ADDR_GLOBAL_STATUS_FLAGS && reg_wdata_i[ST_RESET]
      |=> !st.global_status_flags[ST_RESET];
  endproperty
  a_w1c: assert property (p_w1c) else $error("reset flag not cleared");

  property p_sticky;
    st.global_status_flags[ST_UVCP] && !(reg_wr_i && reg_addr_i == ADDR_GLOBAL_STATUS_FLAGS && reg_wdata_i[ST_UVCP])
      |=> st.global_status_flags[ST_UVCP];
  endproperty
  a_sticky: assert property (p_sticky) else $error("undervolt flag lost");

  property p_uv_set;
    pump_uv_i |=> st.global_status_flags[ST_UVCP] ##0 st.hold_off;
  endproperty
  a_uv_set: assert property (p_uv_set) else $error("undervolt not latched");

  property p_drv_keep;
    st.global_status_flags[ST_DRV] && !temp_ok_i |=> st.global_status_flags[ST_DRV];
  endproperty
  a_drv_keep: assert property (p_drv_keep) else $error("drv error cleared hot");

  property p_drv_set;
    drv_shutdown_i |=> st.global_status_flags[ST_DRV];
  endproperty
  a_drv_set: assert property (p_drv_set) else $error("drv error not set");

  property p_count;
    reg_wr_i && uart_mode_i |=> st.uart_write_counter == $past(st.uart_write_counter) + 8'h01;
  endproperty
  a_count: assert property (p_count) else $error("uart write not counted");

  property p_no_count;
    !(reg_wr_i && uart_mode_i) |=> $stable(st.uart_write_counter);
  endproperty
  a_no_count: assert property (p_no_count) else $error("counter moved");

  property p_halt;
    st.global_configuration[GC_STOP_EN] && enc_a_halt_pin_i ##1 st.global_configuration[GC_STOP_EN][*2]
      |=> seq_halt_o;
  endproperty
  a_halt: assert property (p_halt) else $error("halt missed");

  property p_fault_oc;
    !st.global_configuration[GC_FAULT_PP] && fault_req_i |=> !fault_out_pin_o && fault_out_pin_oe_o;
  endproperty
  a_fault_oc: assert property (p_fault_oc) else $error("fault pin style");

  property p_cmp_pp;
    st.global_configuration[GC_CMP_PP] |=> compare_out_pin_oe_o && compare_out_pin_o == $past(compare_req_i);
  endproperty
  a_cmp_pp: assert property (p_cmp_pp) else $error("compare pin style");

  property p_addr;
    $stable(st.ncfg)[*2] ##0 st.s2[P_NEXT] |=> uart_node_address_o == $past(st.ncfg[7:0]) + 8'h01;
  endproperty
  a_addr: assert property (p_addr) else $error("node address wrong");

  c_clear: cover property (reg_wr_i && reg_addr_i == ADDR_GLOBAL_STATUS_FLAGS ##1 st.global_status_flags == '0);
  c_wrap: cover property (st.uart_write_counter == 8'hFF ##1 st.uart_write_counter == 8'h00);
  c_direct: cover property (st.global_configuration[GC_DIRECT] ##1 coil_b_o != '0);
  c_halt: cover property (seq_halt_o);
endmodule
`default_nettype wire

/* common/gcsb_pkg.sv */
// gcsb_pkg: register map, field positions and reset values of
// the global configuration and status bank.
// assumes a register port on sys_clk_i from the serial front end.
package gcsb_pkg;
  // register addresses
  localparam logic [6:0] ADDR_GLOBAL_CONFIGURATION   = 7'h00;
  localparam logic [6:0] ADDR_GLOBAL_STATUS_FLAGS   = 7'h01;
  localparam logic [6:0] ADDR_UART_WRITE_COUNTER   = 7'h02;
  localparam logic [6:0] ADDR_NODECFG = 7'h03;
  localparam logic [6:0] ADDR_INPUT   = 7'h04;
  // widths
  localparam int AW      = 7;
  localparam int DW      = 32;
  localparam int GLOBAL_CONFIGURATION_W = 18;
  localparam int GLOBAL_STATUS_FLAGS_W = 3;
  localparam int CNT_W   = 8;
  localparam int NCFG_W  = 12;
  localparam int COIL_W  = 9;
  // global configuration bit positions
  localparam int GC_FAULT_PP = 12;
  localparam int GC_CMP_PP   = 13;
  localparam int GC_SMALL_HY = 14;
  localparam int GC_STOP_EN  = 15;
  localparam int GC_DIRECT   = 16;
  localparam int GC_TEST     = 17;
  // status bit positions
  localparam int ST_RESET = 0;
  localparam int ST_DRV   = 1;
  localparam int ST_UVCP  = 2;
  // node config fields
  localparam int NC_ADDR_LSB  = 0;
  localparam int NC_DLY_LSB   = 8;
  localparam int NC_DLY_W     = 4;
  // input readout bit positions
  localparam int IN_LEFT   = 0;
  localparam int IN_RIGHT  = 1;
  localparam int IN_SDMODE = 6;
  // motion target coil fields
  localparam int COIL_A_LSB = 0;
  localparam int COIL_B_LSB = 16;
  // reset values
  localparam logic [GLOBAL_CONFIGURATION_W-1:0] GLOBAL_CONFIGURATION_RST = 18'h00008;
  localparam logic [GLOBAL_STATUS_FLAGS_W-1:0] GLOBAL_STATUS_FLAGS_RST = 3'h1;
  localparam logic [CNT_W-1:0]   CNT_RST   = 8'h00;
  localparam logic [NCFG_W-1:0]  NCFG_RST  = 12'h000;
  // reply delay: odd multiple of this many bit times
  localparam logic [7:0] DLY_UNIT = 8'h08;
  // synchronised pins: left, right, ext_step_source_sel, enc a, next address
  localparam int NPIN = 5;
  localparam int P_LEFT = 0;
  localparam int P_RIGHT = 1;
  localparam int P_SD = 2;
  localparam int P_ENCA = 3;
  localparam int P_NEXT = 4;
endpackage

/* test/gcsb_pins.sv */
// gcsb_pins: board side of the two diagnostic pins.
// assumes a pull-up on each pin; the bank drives level and enable.
`timescale 1ns/1ps
`default_nettype none
module gcsb_pins
(
  // bank pin drivers
  input  wire logic fault_o_i,
  input  wire logic fault_oe_i,
  input  wire logic cmp_o_i,
  input  wire logic cmp_oe_i,
  // resolved pin levels
  output logic      fault_wire_o,
  output logic      cmp_wire_o
);
  // a released pin floats up to the pull-up level
  assign fault_wire_o = fault_oe_i ? fault_o_i : 1'b1;
  assign cmp_wire_o   = cmp_oe_i ? cmp_o_i : 1'b1;
endmodule
`default_nettype wire

/* test/tb.sv */
// tb: register, status, counter, node config and pin checks of the bank.
// assumes the bank answers reads one cycle after the read edge.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import gcsb_pkg::*;
  logic        clk = 0, srst = 1, wr = 0, rd = 0, uart = 0, dsd = 0, tok = 1, uv = 0;
  logic        freq = 0, creq = 0, lft = 0, rgt = 0, sdm = 0, enca = 0, nxt = 0, rd_seen = 0;
  logic [6:0]  addr = 0;
  logic [31:0] wdata = 0, tgt = 0, rdat, d;
  logic [1:0]  hold = 0;
  logic [17:0] gc;
  logic [8:0]  ca, cb;
  logic [7:0]  nad, rdl, exp_cnt = 0, na;
  logic        fo, foe, co, coe, halt, hys, dm, pen, hoff, fw, cw;
  logic [1:0]  psel;
  logic [31:0] exp_q[$], msk_q[$];
  int          err_total = 0, cmp_count = 0;
  // clock
  always #5 clk = ~clk;
  gcsb_bank i_dut (.sys_clk_i(clk), .srst_i(srst), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .uart_mode_i(uart), .reg_rdata_o(rdat), .drv_shutdown_i(dsd), .temp_ok_i(tok),
    .pump_uv_i(uv), .fault_req_i(freq), .compare_req_i(creq), .motion_target_reg_i(tgt),
    .hold_current_setting_i(hold), .left_ref_pin_i(lft), .right_ref_pin_i(rgt), .ext_step_source_sel_i(sdm),
    .enc_a_halt_pin_i(enca), .address_increment_pin_i(nxt), .fault_out_pin_o(fo), .fault_out_pin_oe_o(foe),
    .compare_out_pin_o(co), .compare_out_pin_oe_o(coe), .global_configuration_o(gc), .seq_halt_o(halt), .small_hyst_o(hys),
    .direct_mode_o(dm), .coil_a_o(ca), .coil_b_o(cb), .probe_en_o(pen), .probe_sel_o(psel),
    .drv_hold_off_o(hoff), .uart_node_address_o(nad), .reply_delay_bits_o(rdl));
  gcsb_pins i_pins (.fault_o_i(fo), .fault_oe_i(foe), .cmp_o_i(co), .cmp_oe_i(coe),
    .fault_wire_o(fw), .cmp_wire_o(cw));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [6:0] a, input logic [31:0] dv, input logic u);
    @(negedge clk);
    wr = 1; addr = a; wdata = dv; uart = u;
    if (u) exp_cnt++;
    @(negedge clk);
    wr = 0;
  endtask
  task automatic rd_reg(input logic [6:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(negedge clk);
    rd = 1; addr = a;
    @(negedge clk);
    rd = 0;
  endtask
  task automatic complete_run;
    if (err_total == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // read answers are compared against the oldest note
  always @(posedge clk) rd_seen <= rd & ~srst;
  always @(negedge clk)
  begin
    if (rd_seen)
    begin
      check(rdat & msk_q[0], exp_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  // watchdog against a hang
  initial
  begin
    #200000;
    err_total++;
    complete_run();
  end
  // main sequence
  initial
  begin
    void'($urandom(32'h2e355c51));
    repeat (16) @(negedge clk);
    srst = 0;
    rd_reg(ADDR_GLOBAL_STATUS_FLAGS, 32'h1, 32'h7);
    rd_reg(ADDR_GLOBAL_CONFIGURATION, 32'(GLOBAL_CONFIGURATION_RST), '1);
    rd_reg(ADDR_NODECFG, 0, '1);
    rd_reg(7'h7F, 0, '1);
    check(32'(rdl), 32'h8);
    wr_reg(ADDR_GLOBAL_STATUS_FLAGS, 0, 0);
    rd_reg(ADDR_GLOBAL_STATUS_FLAGS, 32'h1, 32'h7);
    wr_reg(ADDR_GLOBAL_STATUS_FLAGS, 1, 0);
    rd_reg(ADDR_GLOBAL_STATUS_FLAGS, 0, 32'h7);
    tok = 0; dsd = 1;
    @(negedge clk);
    dsd = 0;
    wr_reg(ADDR_GLOBAL_STATUS_FLAGS, 2, 0);
    rd_reg(ADDR_GLOBAL_STATUS_FLAGS, 32'h2, 32'h7);
    tok = 1;
    wr_reg(ADDR_GLOBAL_STATUS_FLAGS, 2, 0);
    rd_reg(ADDR_GLOBAL_STATUS_FLAGS, 0, 32'h7);
    uv = 1;
    repeat (2) @(negedge clk);
    check(32'(hoff), 1);
    wr_reg(ADDR_GLOBAL_STATUS_FLAGS, 4, 0);
    rd_reg(ADDR_GLOBAL_STATUS_FLAGS, 32'h4, 32'h7);
    uv = 0;
    repeat (2) @(negedge clk);
    check(32'(hoff), 0);
    for (int f = 0; f < 16; f++)
    begin
      na = 8'($urandom_range(253));
      nxt = f[0];
      wr_reg(ADDR_NODECFG, {20'h0, 4'(f), na}, 0);
      repeat (4) @(negedge clk);
      check(32'(nad), 32'(na) + 32'(f[0]));
      check(32'(rdl), 32'((2 * (f >> 1) + 1) * 8));
    end
    for (int k = 0; k < 8; k++)
    begin
      freq = k[0]; creq = k[1];
      wr_reg(ADDR_GLOBAL_CONFIGURATION, 32'(GLOBAL_CONFIGURATION_RST) | (32'(k[2]) << GC_FAULT_PP) | (32'(k[2]) << GC_CMP_PP), 0);
      repeat (3) @(negedge clk);
      check(32'(fw), 32'(k[2] ? k[0] : !k[0]));
      check(32'(foe), 32'(k[2] | k[0]));
      check(32'(cw), 32'(k[2] ? k[1] : !k[1]));
      check(32'(coe), 32'(k[2] | k[1]));
      check(32'(gc), 32'(GLOBAL_CONFIGURATION_RST) | (32'(k[2]) << GC_FAULT_PP) | (32'(k[2]) << GC_CMP_PP));
    end
    enca = 1; tgt = $urandom; hold = 2'($urandom);
    wr_reg(ADDR_GLOBAL_CONFIGURATION, 32'h3C008, 0);
    repeat (5) @(negedge clk);
    check(32'(hys), 1);
    check(32'(halt), 1);
    check(32'(dm), 1);
    check(32'(ca), 32'(tgt[8:0]));
    check(32'(cb), 32'(tgt[24:16]));
    check(32'({pen, psel}), 32'({1'b1, hold}));
    enca = 0;
    wr_reg(ADDR_GLOBAL_CONFIGURATION, 32'(GLOBAL_CONFIGURATION_RST), 0);
    repeat (5) @(negedge clk);
    check(32'({hys, halt, ca}), 0);
    for (int k = 0; k < 4; k++)
    begin
      {lft, rgt, sdm} = 3'($urandom);
      wr_reg(ADDR_INPUT, '1, 0);
      repeat (4) @(negedge clk);
      rd_reg(ADDR_INPUT, {25'h0, sdm, 4'h0, rgt, lft}, 32'h43);
    end
    for (int i = 0; i < 260; i++)
    begin
      d = $urandom & 32'h0FFFF;
      wr_reg(ADDR_GLOBAL_CONFIGURATION, d, 1);
    end
    rd_reg(ADDR_GLOBAL_CONFIGURATION, d, '1);
    rd_reg(ADDR_UART_WRITE_COUNTER, 32'(exp_cnt), '1);
    rd_reg(ADDR_UART_WRITE_COUNTER, 32'(exp_cnt), '1);
    repeat (3) wr_reg(ADDR_GLOBAL_STATUS_FLAGS, 0, 0);
    rd_reg(ADDR_UART_WRITE_COUNTER, 32'(exp_cnt), '1);
    wr_reg(ADDR_GLOBAL_STATUS_FLAGS, 1, 0);
    @(negedge clk);
    srst = 1;
    repeat (2) @(negedge clk);
    srst = 0; exp_cnt = 0;
    rd_reg(ADDR_GLOBAL_STATUS_FLAGS, 32'h1, 32'h7);
    rd_reg(ADDR_GLOBAL_CONFIGURATION, 32'(GLOBAL_CONFIGURATION_RST), '1);
    rd_reg(ADDR_UART_WRITE_COUNTER, 0, '1);
    repeat (3) @(negedge clk);
    complete_run();
  end
endmodule
`default_nettype wire
